// file: logic/gdf_pkg.sv
// package for the gate driver serial register and fault status block
// shared by the design and the bench; no clocks or resets here
package gdf_pkg;
	localparam int unsigned GDF_FRAME_BITS = 16;
	localparam int unsigned GDF_DATA_BITS = 11;
	localparam int unsigned GDF_ADDR_BITS = 4;
	localparam int unsigned GDF_BIT_CNT_W = 5;
	localparam logic [4:0] GDF_FRAME_LEN = 5'h10;
	localparam int unsigned GDF_RW_POS = 15;
	localparam int unsigned GDF_ADDR_MSB = 14;
	localparam int unsigned GDF_ADDR_LSB = 11;

	localparam logic [3:0] GDF_ADDR_FAULT1 = 4'h0;
	localparam logic [3:0] GDF_ADDR_FAULT2 = 4'h1;
	localparam logic [3:0] GDF_ADDR_DRVCTL = 4'h2;
	localparam logic [3:0] GDF_ADDR_GDHS = 4'h3;
	localparam logic [3:0] GDF_ADDR_GDLS = 4'h4;
	localparam logic [3:0] GDF_ADDR_OCP = 4'h5;
	localparam logic [3:0] GDF_ADDR_CSA = 4'h6;
	localparam logic [3:0] GDF_ADDR_RSVD = 4'h7;

	localparam logic [10:0] GDF_RST_ZERO = 11'h000;
	localparam logic [10:0] GDF_RST_DRVCTL = 11'h000;
	localparam logic [10:0] GDF_RST_GDHS = 11'h377;
	localparam logic [10:0] GDF_RST_GDLS = 11'h777;
	localparam logic [10:0] GDF_RST_OCP = 11'h145;
	localparam logic [10:0] GDF_RST_CSA = 11'h283;

	// field positions
	localparam int unsigned GDF_CLR_POS = 0;
	localparam int unsigned GDF_DIS_GDF_POS = 8;
	localparam int unsigned GDF_DIS_PUMP_UNDERVOLTAGE_FLAG_POS = 9;
	localparam int unsigned GDF_OTW_REP_POS = 7;
	localparam int unsigned GDF_DIS_SEN_POS = 5;
	localparam int unsigned GDF_LOCK_MSB = 10;
	localparam int unsigned GDF_LOCK_LSB = 8;
	localparam logic [2:0] GDF_LOCK_ON = 3'h6;
	localparam logic [2:0] GDF_LOCK_OFF = 3'h3;
	localparam logic [10:0] GDF_DRV_LOCK_MASK = 11'h007;
	localparam logic [10:0] GDF_HS_LOCK_MASK = 11'h700;

	// timing
	localparam int unsigned GDF_CLK_MHZ = 50;
	localparam int unsigned GDF_T_SLEEP_US = 100;
	localparam int unsigned GDF_T_WAKE_US = 1000;
	localparam int unsigned GDF_T_RST_US = 20;
	localparam int unsigned GDF_SLEEP_CYC = GDF_T_SLEEP_US * GDF_CLK_MHZ;
	localparam int unsigned GDF_WAKE_CYC = GDF_T_WAKE_US * GDF_CLK_MHZ;
	localparam int unsigned GDF_RST_CYC = GDF_T_RST_US * GDF_CLK_MHZ;
	localparam int unsigned GDF_TMR_W = 20;

	typedef enum {GDF_SLEEP, GDF_WAKING, GDF_OPER, GDF_LOW_PULSE, GDF_FALLING} gdf_mode_t;

	// raw fault conditions from the analog monitors
	typedef struct packed {
		logic overtemp_shutdown;
		logic overtemp_warning;
		logic supply_undervoltage;
		logic pump_undervoltage;
		logic [5:0] drain_source_oc;
		logic [5:0] gate_fault;
		logic [2:0] sense_oc;
	} gdf_cond_t;

	// power and gate stage controls
	typedef struct packed {
		logic gates_enable;
		logic charge_pump_on;
		logic logic_regulator_on;
		logic serial_on;
		logic gate_pulldown;
	} gdf_power_t;

	// one received frame, carried across domains
	typedef struct packed {
		logic access_type_bit;
		logic [3:0] addr;
		logic [10:0] data;
	} gdf_frame_t;
endpackage

// file: logic/gdf_core.sv
// gate driver serial register interface, mode control and fault status
// assumes i_core_clk 50 MHz, i_sys_rst synchronous; serial clock and enable are asynchronous pins
`timescale 1ns/1ps
module gdf_core import gdf_pkg::*; #(
	parameter int unsigned SLEEP_CYC = GDF_SLEEP_CYC,
	parameter int unsigned WAKE_CYC = GDF_WAKE_CYC,
	parameter int unsigned RST_CYC = GDF_RST_CYC
) (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_enable_pin,
	input wire logic i_enable_pin_driven,
	input wire gdf_cond_t i_cond,
	input wire logic i_serial_clk,
	input wire logic i_chip_select_n,
	input wire logic i_serial_in,
	output logic o_serial_out,
	output logic o_serial_out_en,
	output logic o_fault_indicator_n,
	output gdf_power_t o_power,
	output logic o_frame_error,
	output logic [10:0] o_driver_control,
	output logic [10:0] o_high_side_gate_drive,
	output logic [10:0] o_low_side_gate_drive,
	output logic [10:0] o_overcurrent_control,
	output logic [10:0] o_sense_amp_control
);
	// ---------------- link domain (serial clock) ----------------
	// chip select acts as async reset of the link state so a stopped clock leaves nothing pending
	logic [4:0] rx_cnt_reg;
	logic [15:0] rx_shift_reg;
	logic [15:0] tx_shift_reg;
	logic [10:0] snap_reg;
	logic [10:0] rd_sync1_reg;
	logic [10:0] rd_sync2_reg;
	logic [10:0] rd_word;
	logic [15:0] held_frame_reg;
	logic [4:0] held_cnt_reg;
	gdf_power_t power_reg;
	logic [3:0] rd_addr_reg;
	logic [3:0] live_addr_sync1;
	logic [3:0] live_addr_sync2;

	// sample on falling edge, MSB first
	always_ff @(negedge i_serial_clk or posedge i_chip_select_n) begin
		if (i_chip_select_n) begin
			rx_cnt_reg <= 5'h00;
			rx_shift_reg <= 16'h0000;
		end else begin
			rx_shift_reg <= {rx_shift_reg[14:0], i_serial_in};
			if (rx_cnt_reg != 5'h1F) begin
				rx_cnt_reg <= rx_cnt_reg + 5'h01;
			end
		end
	end

	// select release freezes the word before the link state is wiped; stays put until the next frame ends
	always_ff @(posedge i_chip_select_n) begin
		held_frame_reg <= rx_shift_reg;
		held_cnt_reg <= rx_cnt_reg;
	end

	// shifts on rising edge and only ever loads zeros; the don't-care bits and register content come from the decode below
	always_ff @(posedge i_serial_clk or posedge i_chip_select_n) begin
		if (i_chip_select_n) begin
			tx_shift_reg <= 16'h0000;
		end else begin
			tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
		end
	end

	// readback value is sampled once the address is in (after bit 11 on falling edge)
	always_ff @(negedge i_serial_clk or posedge i_chip_select_n) begin
		if (i_chip_select_n) begin
			snap_reg <= 11'h000;
		end else if (rx_cnt_reg == 5'h04) begin
			snap_reg <= rd_word;
		end
	end

	// output: 5 don't-care bits driven low, then old register value, so write returns old data
	always_comb begin
		if (rx_cnt_reg < 5'h05) begin
			o_serial_out = 1'b0;
		end else if (rx_cnt_reg < GDF_FRAME_LEN) begin
			o_serial_out = snap_reg[4'hA - 4'(rx_cnt_reg - 5'h05)];
		end else begin
			o_serial_out = 1'b0;
		end
	end
	assign o_serial_out_en = ~i_chip_select_n & power_reg.serial_on;

	// rd_word: address from 3 shifted bits plus the live input bit, selects from core registers via synchronised copy
	logic [3:0] live_addr;
	assign live_addr = {rx_shift_reg[2:0], i_serial_in};

	// ---------------- core domain ----------------
	logic [2:0] en_sync_reg;
	logic [2:0] cs_sync_reg;
	logic enable_level;
	logic cs_level_reg;
	gdf_mode_t mode_reg;
	logic [GDF_TMR_W-1:0] tmr_reg;
	logic settle_reg;
	logic pulse_clear;
	logic [10:0] regs_reg [2:6];
	logic locked_reg;
	logic [10:0] status1;
	logic [10:0] status2;
	logic any_fault;

	// floating enable reads as high
	wire enable_raw = i_enable_pin | ~i_enable_pin_driven;

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			en_sync_reg <= 3'h7;
			cs_sync_reg <= 3'h7;
			enable_level <= 1'b1;
			cs_level_reg <= 1'b1;
		end else begin
			en_sync_reg <= {en_sync_reg[1:0], enable_raw};
			cs_sync_reg <= {cs_sync_reg[1:0], i_chip_select_n};
			if (en_sync_reg[1] == en_sync_reg[2]) begin
				enable_level <= en_sync_reg[2];
			end
			if (cs_sync_reg[1] == cs_sync_reg[2]) begin
				cs_level_reg <= cs_sync_reg[2];
			end
		end
	end

	// chip-select rising edge: frame done, link state is quiet and stable until next frame
	wire frame_end = cs_level_reg == 1'b0 && cs_sync_reg[2] && cs_sync_reg[1];

	// mode control
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			mode_reg <= GDF_WAKING;
			tmr_reg <= '0;
		end else begin
			unique case (mode_reg)
				GDF_SLEEP: begin
					tmr_reg <= '0;
					if (enable_level) begin
						mode_reg <= GDF_WAKING;
					end
				end
				GDF_WAKING: begin
					tmr_reg <= tmr_reg + 1'b1;
					if (!enable_level) begin
						mode_reg <= GDF_FALLING;
						tmr_reg <= '0;
					end else if (tmr_reg >= GDF_TMR_W'(WAKE_CYC - 1)) begin
						mode_reg <= GDF_OPER;
					end
				end
				GDF_OPER: begin
					tmr_reg <= '0;
					if (!enable_level) begin
						mode_reg <= GDF_LOW_PULSE;
					end
				end
				GDF_LOW_PULSE: begin
					tmr_reg <= tmr_reg + 1'b1;
					if (enable_level) begin
						mode_reg <= GDF_OPER; // short pulse only clears faults
					end else if (tmr_reg >= GDF_TMR_W'(RST_CYC - 1)) begin
						mode_reg <= GDF_FALLING; // long low: full shutdown
					end
				end
				GDF_FALLING: begin
					tmr_reg <= tmr_reg + 1'b1;
					if (tmr_reg >= GDF_TMR_W'(SLEEP_CYC - 1)) begin
						mode_reg <= GDF_SLEEP;
					end
				end
			endcase
		end
	end

	assign pulse_clear = mode_reg == GDF_LOW_PULSE && enable_level;
	wire operating = mode_reg == GDF_OPER || mode_reg == GDF_LOW_PULSE;

	// latched status flags; set wins over clear
	logic tsd_reg;
	logic [5:0] ds_oc_reg;
	logic [5:0] gate_flt_reg;
	logic [2:0] sense_oc_reg;
	logic pump_undervoltage_flag_reg;
	logic supply_undervoltage_flag_reg;
	wire clr_cmd = regs_reg[GDF_ADDR_DRVCTL][GDF_CLR_POS] | pulse_clear;
	wire dis_gdf = regs_reg[GDF_ADDR_DRVCTL][GDF_DIS_GDF_POS];
	wire dis_pump_undervoltage_flag = regs_reg[GDF_ADDR_DRVCTL][GDF_DIS_PUMP_UNDERVOLTAGE_FLAG_POS];
	wire dis_sen = regs_reg[GDF_ADDR_CSA][GDF_DIS_SEN_POS];
	wire otw_rep = regs_reg[GDF_ADDR_DRVCTL][GDF_OTW_REP_POS];

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			tsd_reg <= 1'b0;
			ds_oc_reg <= 6'h00;
			gate_flt_reg <= 6'h00;
			sense_oc_reg <= 3'h0;
			pump_undervoltage_flag_reg <= 1'b0;
			supply_undervoltage_flag_reg <= 1'b0;
		end else begin
			// no disable bit reaches this flag
			tsd_reg <= i_cond.overtemp_shutdown | (tsd_reg & ~clr_cmd);
			ds_oc_reg <= i_cond.drain_source_oc | (ds_oc_reg & ~{6{clr_cmd}});
			gate_flt_reg <= (i_cond.gate_fault & ~{6{dis_gdf}}) | (gate_flt_reg & ~{6{clr_cmd}});
			sense_oc_reg <= (i_cond.sense_oc & ~{3{dis_sen}}) | (sense_oc_reg & ~{3{clr_cmd}});
			pump_undervoltage_flag_reg <= (i_cond.pump_undervoltage & ~dis_pump_undervoltage_flag) | (pump_undervoltage_flag_reg & ~clr_cmd);
			supply_undervoltage_flag_reg <= i_cond.supply_undervoltage | (supply_undervoltage_flag_reg & ~clr_cmd);
		end
	end

	// status layout
	// live overtemp, not the latched flag, so bit 10 follows the pin after recovery
	assign any_fault = i_cond.overtemp_shutdown | (|ds_oc_reg) | (|gate_flt_reg) | (|sense_oc_reg) | pump_undervoltage_flag_reg | supply_undervoltage_flag_reg
		| (otw_rep & i_cond.overtemp_warning);
	assign status1 = {any_fault, |ds_oc_reg, |gate_flt_reg, supply_undervoltage_flag_reg, tsd_reg, ds_oc_reg};
	assign status2 = {sense_oc_reg, i_cond.overtemp_warning, pump_undervoltage_flag_reg, gate_flt_reg};

	// readback mux for the link; follows the live address, crosses via sync pair below
	logic [10:0] rd_core;
	always_comb begin
		unique case (rd_addr_reg)
			GDF_ADDR_FAULT1: rd_core = status1;
			GDF_ADDR_FAULT2: rd_core = status2;
			GDF_ADDR_DRVCTL, GDF_ADDR_GDHS, GDF_ADDR_GDLS, GDF_ADDR_OCP, GDF_ADDR_CSA: rd_core = regs_reg[rd_addr_reg];
			default: rd_core = GDF_RST_ZERO;
		endcase
	end
	// limitation: readback uses the current frame's live address decode, resolved through the sync stages before its sample
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			rd_sync1_reg <= 11'h000;
			rd_sync2_reg <= 11'h000;
			rd_addr_reg <= 4'h0;
		end else begin
			rd_addr_reg <= live_addr_sync2;
			rd_sync1_reg <= rd_core;
			rd_sync2_reg <= rd_sync1_reg;
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			live_addr_sync1 <= 4'h0;
			live_addr_sync2 <= 4'h0;
		end else begin
			live_addr_sync1 <= live_addr;
			live_addr_sync2 <= live_addr_sync1;
		end
	end
	assign rd_word = rd_sync2_reg;

	// frame taken at chip-select release; link registers are static then
	wire frame_ok = held_cnt_reg == GDF_FRAME_LEN;
	gdf_frame_t frame;
	assign frame = held_frame_reg;

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_frame_error <= 1'b0;
		end else begin
			o_frame_error <= frame_end && !frame_ok && power_reg.serial_on;
		end
	end

	// register writes with lock and self-clearing clear bit
	wire wr_ok = frame_end && frame_ok && power_reg.serial_on && !frame.access_type_bit;
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			regs_reg[GDF_ADDR_DRVCTL] <= GDF_RST_DRVCTL;
			regs_reg[GDF_ADDR_GDHS] <= GDF_RST_GDHS;
			regs_reg[GDF_ADDR_GDLS] <= GDF_RST_GDLS;
			regs_reg[GDF_ADDR_OCP] <= GDF_RST_OCP;
			regs_reg[GDF_ADDR_CSA] <= GDF_RST_CSA;
			locked_reg <= 1'b0;
		end else begin
			regs_reg[GDF_ADDR_DRVCTL][GDF_CLR_POS] <= 1'b0;
			if (wr_ok) begin
				if (frame.addr == GDF_ADDR_GDHS) begin
					if (frame.data[GDF_LOCK_MSB:GDF_LOCK_LSB] == GDF_LOCK_ON) begin
						locked_reg <= 1'b1;
					end else if (frame.data[GDF_LOCK_MSB:GDF_LOCK_LSB] == GDF_LOCK_OFF) begin
						locked_reg <= 1'b0;
					end
				end
				if (!locked_reg) begin
					if (frame.addr >= GDF_ADDR_DRVCTL && frame.addr <= GDF_ADDR_CSA) begin
						regs_reg[frame.addr] <= frame.data; // reserved address 7 ignored
					end
				end else if (frame.addr == GDF_ADDR_DRVCTL) begin
					regs_reg[GDF_ADDR_DRVCTL] <= (regs_reg[GDF_ADDR_DRVCTL] & ~GDF_DRV_LOCK_MASK)
						| (frame.data & GDF_DRV_LOCK_MASK);
				end else if (frame.addr == GDF_ADDR_GDHS) begin
					regs_reg[GDF_ADDR_GDHS] <= (regs_reg[GDF_ADDR_GDHS] & ~GDF_HS_LOCK_MASK)
						| (frame.data & GDF_HS_LOCK_MASK);
				end
			end
		end
	end

	// power and gate stage; stalls while any shutdown-class fault is live
	wire trip_now = i_cond.overtemp_shutdown | i_cond.supply_undervoltage;
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			power_reg <= '0;
			settle_reg <= 1'b1;
		end else begin
			power_reg.logic_regulator_on <= mode_reg != GDF_SLEEP;
			power_reg.serial_on <= operating;
			power_reg.charge_pump_on <= operating && !i_cond.overtemp_shutdown;
			power_reg.gates_enable <= operating && !trip_now && !(|gate_flt_reg) && !pump_undervoltage_flag_reg;
			power_reg.gate_pulldown <= !operating || i_cond.supply_undervoltage;
			settle_reg <= mode_reg == GDF_WAKING || mode_reg == GDF_FALLING;
		end
	end

	// indicator follows live overtemp, then releases automatically
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_fault_indicator_n <= 1'b0;
		end else begin
			o_fault_indicator_n <= !(settle_reg || any_fault);
		end
	end

	assign o_power = power_reg;
	assign o_driver_control = regs_reg[GDF_ADDR_DRVCTL];
	assign o_high_side_gate_drive = regs_reg[GDF_ADDR_GDHS];
	assign o_low_side_gate_drive = regs_reg[GDF_ADDR_GDLS];
	assign o_overcurrent_control = regs_reg[GDF_ADDR_OCP];
	assign o_sense_amp_control = regs_reg[GDF_ADDR_CSA];
endmodule

// file: bench/gdf_spi_master.sv
// serial master model standing on the link pins of gdf_core
// assumes the bench calls xfer; serial clock stands still between frames
`timescale 1ns/1ps
module gdf_spi_master (
	output logic o_serial_clk,
	output logic o_chip_select_n,
	output logic o_serial_in,
	input wire logic i_serial_out,
	input wire logic i_serial_out_en
);
	logic last_sdo;
	logic sdo_wire;
	// released line shows the inverse of its last value, never a stale copy
	assign sdo_wire = i_serial_out_en ? i_serial_out : ~last_sdo;
	always @(i_serial_out or i_serial_out_en) if (i_serial_out_en) last_sdo = i_serial_out;
	initial begin
		o_serial_clk = 1'b0;
		o_chip_select_n = 1'b1;
		o_serial_in = 1'b0;
		last_sdo = 1'b0;
	end
	// clock low at both select edges, select high 480 ns after each frame
	task automatic xfer(input logic [16:0] word, input int nbits, output logic [16:0] rx);
		rx = '0;
		o_chip_select_n = 1'b0;
		#40;
		for (int i = nbits - 1; i >= 0; i--) begin
			o_serial_in = word[i]; // msb first, set ahead of the rising edge
			// readback address crosses slowly, so hold the last address bit before its sample
			if (i == nbits - 5) #300;
			#8 o_serial_clk = 1'b1;
			#16 rx = {rx[15:0], sdo_wire}; // taken at the falling edge
			o_serial_clk = 1'b0;
			#8;
		end
		#40 o_chip_select_n = 1'b1;
		#480;
	endtask
endmodule

// file: bench/gdf_core_properties.sv
// port-level assertions for gdf_core, bound into every instance
// assumes one core clock domain; serial pins seen as plain levels
`timescale 1ns/1ps
module gdf_core_properties import gdf_pkg::*; #(
	parameter int unsigned SLEEP_CYC = GDF_SLEEP_CYC,
	parameter int unsigned WAKE_CYC = GDF_WAKE_CYC,
	parameter int unsigned RST_CYC = GDF_RST_CYC
) (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_enable_pin,
	input wire logic i_enable_pin_driven,
	input wire gdf_cond_t i_cond,
	input wire logic i_chip_select_n,
	input wire logic o_serial_out_en,
	input wire logic o_fault_indicator_n,
	input wire gdf_power_t o_power,
	input wire logic o_frame_error,
	input wire logic [10:0] o_driver_control,
	input wire logic [10:0] o_high_side_gate_drive,
	input wire logic [10:0] o_low_side_gate_drive,
	input wire logic [10:0] o_overcurrent_control,
	input wire logic [10:0] o_sense_amp_control
);
	logic [20:0] low_cnt_reg;
	logic [20:0] high_cnt_reg;
	logic [54:0] regs;
	assign regs = {o_driver_control, o_high_side_gate_drive, o_low_side_gate_drive, o_overcurrent_control,
		o_sense_amp_control};
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst || !i_enable_pin_driven || i_enable_pin) low_cnt_reg <= '0;
		else low_cnt_reg <= low_cnt_reg + 21'h000001;
	end
	// floating enable counts as high
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst || (i_enable_pin_driven && !i_enable_pin) || i_cond.supply_undervoltage) high_cnt_reg <= '0;
		else high_cnt_reg <= high_cnt_reg + 21'h000001;
	end
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	a_overtemp_shutdown_flag_shuts_gates: assert property (i_cond.overtemp_shutdown [*4] |-> !o_power.gates_enable &&
		!o_power.charge_pump_on && !o_fault_indicator_n) else $error("overtemp did not shut gates");
	a_sleep_after_low: assert property (low_cnt_reg > SLEEP_CYC + RST_CYC + 16 |-> !o_power.serial_on &&
		!o_power.charge_pump_on && !o_power.gates_enable && o_power.gate_pulldown) else $error("no sleep");
	a_wake_holds_off: assert property ($fell(i_sys_rst) |-> !o_power.serial_on [*8]) else $error("early wake");
	a_uv_pulls_gates: assert property (i_cond.supply_undervoltage [*4] |-> o_power.gate_pulldown &&
		!o_power.gates_enable) else $error("gates not pulled down");
	a_reset_holds_low: assert property (disable iff (1'b0) i_sys_rst |=> !o_fault_indicator_n &&
		o_power == '0) else $error("outputs active in reset");
	a_operating_on: assert property (high_cnt_reg > WAKE_CYC + 16 |-> o_power.serial_on &&
		o_power.logic_regulator_on) else $error("not operating");
	a_deselect_hiz: assert property (i_chip_select_n |-> !o_serial_out_en) else $error("output driven");
	a_err_one_pulse: assert property (o_frame_error |-> $past(i_chip_select_n, 2) ##1 !o_frame_error)
		else $error("frame error pulse wrong");
	a_regs_after_frame: assert property (!$stable(regs) && !$past(i_sys_rst) |-> $past(i_chip_select_n) &&
		$past(i_chip_select_n, 3)) else $error("register changed mid frame");
	c_frame_error: cover property ($rose(o_frame_error));
	c_fault_shown: cover property (!o_fault_indicator_n && o_power.serial_on);
	c_sleep: cover property ($fell(o_power.serial_on));
endmodule
bind gdf_core gdf_core_properties #(.SLEEP_CYC(SLEEP_CYC), .WAKE_CYC(WAKE_CYC), .RST_CYC(RST_CYC)) u_props (
	.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_enable_pin(i_enable_pin),
	.i_enable_pin_driven(i_enable_pin_driven), .i_cond(i_cond), .i_chip_select_n(i_chip_select_n),
	.o_serial_out_en(o_serial_out_en), .o_fault_indicator_n(o_fault_indicator_n), .o_power(o_power),
	.o_frame_error(o_frame_error), .o_driver_control(o_driver_control),
	.o_high_side_gate_drive(o_high_side_gate_drive), .o_low_side_gate_drive(o_low_side_gate_drive),
	.o_overcurrent_control(o_overcurrent_control), .o_sense_amp_control(o_sense_amp_control));

// file: bench/gdf_core_tb.sv
// self-checking bench for gdf_core: frames, fault flags, enable modes
// assumes gdf_spi_master on the link pins and the bound checker
`timescale 1ns/1ps
module gdf_core_tb import gdf_pkg::*;;
	localparam int SL = 20;
	localparam int WK = 40;
	localparam int RS = 10;
	logic clk, rst, en, en_drv, sclk, cs_n, sdi, sdo, sdo_en, flt_n, ferr;
	gdf_cond_t cond;
	gdf_power_t pwr;
	logic [10:0] drv, ghs, gls, ocp, csa;
	logic [16:0] rx;
	int fail_count, compares, ferr_seen;
	gdf_core #(.SLEEP_CYC(SL), .WAKE_CYC(WK), .RST_CYC(RS)) DUT (.i_core_clk(clk), .i_sys_rst(rst),
		.i_enable_pin(en), .i_enable_pin_driven(en_drv), .i_cond(cond), .i_serial_clk(sclk),
		.i_chip_select_n(cs_n), .i_serial_in(sdi), .o_serial_out(sdo), .o_serial_out_en(sdo_en),
		.o_fault_indicator_n(flt_n), .o_power(pwr), .o_frame_error(ferr), .o_driver_control(drv),
		.o_high_side_gate_drive(ghs), .o_low_side_gate_drive(gls), .o_overcurrent_control(ocp),
		.o_sense_amp_control(csa));
	gdf_spi_master u_master (.o_serial_clk(sclk), .o_chip_select_n(cs_n), .o_serial_in(sdi),
		.i_serial_out(sdo), .i_serial_out_en(sdo_en));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic xf(input logic [16:0] w, input int n);
		u_master.xfer(w, n, rx);
		cyc(8);
	endtask
	// layout: access type, address, data
	task automatic rd(input logic [3:0] a, input logic [10:0] exp);
		xf({2'b01, a, 11'h000}, 16);
		check(32'(rx[15:0]), 32'({5'h00, exp}));
	endtask
	task automatic wr(input logic [3:0] a, input logic [10:0] d, input logic [10:0] old);
		xf({2'b00, a, d}, 16);
		check(32'(rx[15:0]), 32'({5'h00, old}));
	endtask
	task automatic t_reset_vals;
		logic [10:0] rv [7];
		rv = '{GDF_RST_ZERO, GDF_RST_ZERO, GDF_RST_DRVCTL, GDF_RST_GDHS, GDF_RST_GDLS, GDF_RST_OCP, GDF_RST_CSA};
		for (int a = 0; a < 7; a++) rd(4'(a), rv[a]);
		check({gls, csa}, {GDF_RST_GDLS, GDF_RST_CSA});
		$display("done reset values");
	endtask
	task automatic t_write;
		wr(GDF_ADDR_DRVCTL, 11'h0F0, GDF_RST_DRVCTL);
		wr(GDF_ADDR_OCP, 11'h1AA, GDF_RST_OCP);
		check({drv, ocp}, {11'h0F0, 11'h1AA});
		wr(GDF_ADDR_RSVD, 11'h7FF, 11'h000);
		rd(GDF_ADDR_RSVD, 11'h000);
		wr(GDF_ADDR_FAULT1, 11'h7FF, 11'h000);
		rd(GDF_ADDR_FAULT1, 11'h000);
		$display("done write");
	endtask
	task automatic t_frame;
		int n0;
		n0 = ferr_seen;
		xf({2'b00, GDF_ADDR_OCP, 11'h000} >> 1, 15);
		xf({1'b0, GDF_ADDR_OCP, 11'h000, 1'b0}, 17);
		check(ferr_seen - n0, 2);
		check(ocp, 11'h1AA);
		$display("done frame error");
	endtask
	task automatic t_thermal;
		wr(GDF_ADDR_DRVCTL, 11'h3F0, 11'h0F0);
		cond.overtemp_shutdown <= 1'b1;
		cyc(8);
		check({flt_n, pwr.gates_enable, pwr.charge_pump_on}, 0);
		rd(GDF_ADDR_FAULT1, 11'h440);
		cond.overtemp_shutdown <= 1'b0;
		cyc(8);
		check({flt_n, pwr.gates_enable}, 2'b11);
		rd(GDF_ADDR_FAULT1, 11'h040);
		wr(GDF_ADDR_DRVCTL, 11'h3F1, 11'h3F0);
		check(drv, 11'h3F0);
		rd(GDF_ADDR_FAULT1, 11'h000);
		wr(GDF_ADDR_DRVCTL, 11'h0F0, 11'h3F0);
		$display("done thermal");
	endtask
	task automatic t_status;
		cond.gate_fault <= 6'h21;
		cond.overtemp_warning <= 1'b1;
		cyc(8);
		rd(GDF_ADDR_FAULT2, 11'h0A1);
		rd(GDF_ADDR_FAULT1, 11'h500);
		cond <= '0;
		cyc(8);
		rd(GDF_ADDR_FAULT2, 11'h021);
		en <= 1'b0;
		cyc(4);
		en <= 1'b1;
		cyc(12);
		rd(GDF_ADDR_FAULT2, 11'h000);
		check({flt_n, ocp, drv}, {1'b1, 11'h1AA, 11'h0F0});
		$display("done status");
	endtask
	task automatic t_lock;
		wr(GDF_ADDR_GDHS, 11'h677, GDF_RST_GDHS);
		wr(GDF_ADDR_OCP, 11'h000, 11'h1AA);
		wr(GDF_ADDR_DRVCTL, 11'h004, 11'h0F0);
		check({ocp, drv}, {11'h1AA, 11'h0F4});
		wr(GDF_ADDR_GDHS, 11'h377, 11'h677);
		wr(GDF_ADDR_OCP, 11'h145, 11'h1AA);
		check({ghs, ocp}, {11'h377, 11'h145});
		$display("done lock");
	endtask
	task automatic t_modes;
		en <= 1'b0;
		cyc(SL + RS + 30);
		check(pwr, 5'b00001);
		en <= 1'b1;
		cyc(8);
		check(flt_n, 1'b0);
		cyc(WK + 20);
		check({pwr, flt_n}, 6'b111101);
		rd(GDF_ADDR_FAULT1, 11'h000);
		en_drv <= 1'b0;
		en <= 1'b0;
		cyc(SL + RS + 30);
		check(pwr.serial_on, 1'b1);
		cond.supply_undervoltage <= 1'b1;
		cyc(8);
		check({pwr.gates_enable, pwr.gate_pulldown}, 2'b01);
		$display("done modes");
	endtask
	task automatic print_verdict;
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) if (ferr === 1'b1) ferr_seen++;
	// run needs well under 200 us; 1 ms means a hang
	initial begin
		#1000000;
		fail_count++;
		print_verdict;
	end
	initial begin
		rst = 1'b1;
		en = 1'b1;
		en_drv = 1'b1;
		cond = '0;
		fail_count = 0;
		compares = 0;
		ferr_seen = 0;
		cyc(8);
		rst <= 1'b0;
		cyc(WK + 10);
		t_reset_vals;
		t_write;
		t_frame;
		t_thermal;
		t_status;
		t_lock;
		t_modes;
		print_verdict;
	end
endmodule
